/* File: hw/dp_pkg.sv */
// Constants shared by the premodulation and inverse-sinc front end.
// What this block does
// - Capture data and frame on both edges of the source data clock, slightly delayed.
// - Two-bit delay field at 0x72 bits 1:0 picks one of four capture delays.
// - Two complex paths, each joins one I and one Q stream.
// - Order is premodulation, complex filter, then the later interpolation stages.
// - Real four-stream input allows only premodulation; the filter is bypassed.
// - Premodulation multiplies successive samples by +1 and -1 alternately.
// - Inverse-sinc filter runs at input data rate before any interpolation.
// - Nine taps: c0..c4, then conjugates of c3, c2, c1, c0.
// - Four parallel real filters, real and imaginary parts, combined into I and Q.
// - Coefficients are two's complement in registers 0x20 through 0x27.
// - Widths are 3, 4, 5, 7 and 10 bits; c4 taken as 10 bits.
// - Sample error detector lets software check the capture timing.
package dp_pkg;
    localparam logic [7:0] COEF_BASE_ADDR      = 8'h20;
    localparam logic [7:0] COEF_LAST_ADDR      = 8'h27;
    localparam logic [7:0] CAPTURE_DELAY_ADDR  = 8'h72;
    localparam logic [7:0] PATH_CTRL_ADDR      = 8'h68;
    localparam logic [7:0] CAPTURE_STATUS_ADDR = 8'h69;
    localparam logic [7:0] SED_PATTERN_LO_ADDR = 8'h6A;
    localparam logic [7:0] SED_PATTERN_HI_ADDR = 8'h6B;
    localparam logic [7:0] REG_RESET           = 8'h00;
    localparam int CTRL_PREMOD_BIT = 0;
    localparam int CTRL_REAL_BIT   = 1;
    localparam int CTRL_SED_BIT    = 2;
    localparam int STAT_SED_BIT    = 0;
    localparam int STAT_OVF_BIT    = 1;
    localparam int DELAY_W         = 2;
    // Capture point after each clock edge
    localparam int CAPTURE_DELAY_PS  = 250;
    localparam int CLK_PERIOD_PS     = 5000;
    localparam int CAPTURE_BASE_CYC  = (CAPTURE_DELAY_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CAPTURE_EXTRA_MAX = 3;
    localparam int EDGE_DLY_LEN      = CAPTURE_BASE_CYC + CAPTURE_EXTRA_MAX;
    // Coefficient packing, real then imaginary for each of c0..c4
    localparam int NUM_COEF    = 5;
    localparam int NUM_TAPS    = 9;
    localparam int COEF_MAX_W  = 10;
    localparam int COEF_W      [NUM_COEF] = '{3, 4, 5, 7, 10};
    localparam int COEF_RE_LSB [NUM_COEF] = '{0, 6, 14, 24, 38};
    localparam int COEF_IM_LSB [NUM_COEF] = '{3, 10, 19, 31, 48};
    localparam int FIR_SHIFT   = 9;
    localparam int FIFO_DEPTH  = 16;
    localparam int GROUP_WORDS = 4;
    localparam int NUM_PATHS   = 2;
endpackage

/* File: hw/premod_inverse_sinc_datapath.sv */
// Dual-edge input capture, premodulation and nine-tap complex inverse-sinc filter.
`timescale 1ns/100ps
`default_nettype none
module premod_inverse_sinc_datapath #(
    parameter int DW         = 16,
    parameter int FIFO_DEPTH = dp_pkg::FIFO_DEPTH,
    parameter int FIR_SHIFT  = dp_pkg::FIR_SHIFT
) (
    input  wire logic          clk,
    input  wire logic          rst_b,
    input  wire logic          source_data_clock,
    input  wire logic [DW-1:0] data_in,
    input  wire logic          frame_in,
    input  wire logic [7:0]    reg_addr,
    input  wire logic [7:0]    reg_wdata,
    input  wire logic          reg_we,
    output logic [7:0]         reg_rdata,
    input  wire logic          out_ready,
    output logic               out_valid,
    output logic [DW-1:0]      path0_i,
    output logic [DW-1:0]      path0_q,
    output logic [DW-1:0]      path1_i,
    output logic [DW-1:0]      path1_q
);
    localparam int NP   = dp_pkg::NUM_PATHS;
    localparam int NT   = dp_pkg::NUM_TAPS;
    localparam int GW   = dp_pkg::GROUP_WORDS;
    localparam int ACCW = DW + 16;
    localparam int DL   = dp_pkg::EDGE_DLY_LEN;

    // Saturate a scaled accumulator into the sample width
    function automatic logic signed [DW-1:0] sat_dw(input logic signed [ACCW-1:0] v);
        logic signed [ACCW-1:0] hi;
        logic signed [ACCW-1:0] lo;
        hi = ACCW'((2 ** (DW-1)) - 1);
        lo = -hi - 1;
        if (v > hi) begin
            sat_dw = hi[DW-1:0];
        end else if (v < lo) begin
            sat_dw = lo[DW-1:0];
        end else begin
            sat_dw = v[DW-1:0];
        end
    endfunction

    // ---------------- Pin synchronisers ----------------
    logic          dci_s1_q, dci_s2_q, dci_prev_q;
    logic          frm_s1_q, frm_s2_q;
    logic [DW-1:0] dat_s1_q, dat_s2_q;
    logic [DL-1:0] edge_dly_q, edge_dly_d;
    logic          cap;
    logic [dp_pkg::DELAY_W-1:0] delay_q, delay_d;

    // Both edges count; the chosen tap sets how late after the edge we sample
    always_comb begin
        edge_dly_d = {edge_dly_q[DL-2:0], dci_s2_q ^ dci_prev_q};
        cap        = edge_dly_q[(dp_pkg::CAPTURE_BASE_CYC - 1) + int'(delay_q)];
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            dci_s1_q   <= 1'b0;
            dci_s2_q   <= 1'b0;
            dci_prev_q <= 1'b0;
            frm_s1_q   <= 1'b0;
            frm_s2_q   <= 1'b0;
            dat_s1_q   <= '0;
            dat_s2_q   <= '0;
            edge_dly_q <= '0;
        end else begin
            dci_s1_q   <= source_data_clock;
            dci_s2_q   <= dci_s1_q;
            dci_prev_q <= dci_s2_q;
            frm_s1_q   <= frame_in;
            frm_s2_q   <= frm_s1_q;
            dat_s1_q   <= data_in;
            dat_s2_q   <= dat_s1_q;
            edge_dly_q <= edge_dly_d;
        end
    end

    // ---------------- Word assembly into I/Q groups ----------------
    logic [1:0]         wcnt_q, wcnt_d;
    logic [3*DW-1:0]    grp_q, grp_d;
    logic               push_q, push_d;
    logic [GW*DW-1:0]   pdata_q, pdata_d;
    logic               fifo_in_ready;
    logic               sed_hit, ovf_hit;
    logic [7:0]         ctrl_q, ctrl_d;
    logic [15:0]        pattern_q, pattern_d;
    logic [1:0]         idx;

    // Frame high restarts the group: I0, Q0, I1, Q1
    always_comb begin
        wcnt_d  = wcnt_q;
        grp_d   = grp_q;
        pdata_d = pdata_q;
        push_d  = 1'b0;
        sed_hit = 1'b0;
        idx     = frm_s2_q ? 2'h0 : wcnt_q;
        if (cap) begin
            if (idx == 2'h3) begin
                pdata_d = {dat_s2_q, grp_q};
                push_d  = 1'b1;
                wcnt_d  = 2'h0;
            end else begin
                grp_d[int'(idx)*DW +: DW] = dat_s2_q;
                wcnt_d = idx + 2'h1;
            end
            // Known pattern on the first word exposes a bad capture point
            if (idx == 2'h0 && ctrl_q[dp_pkg::CTRL_SED_BIT] &&
                dat_s2_q != pattern_q[DW-1:0]) begin
                sed_hit = 1'b1;
            end
        end
        // The source cannot be stalled, so a full FIFO drops the group
        ovf_hit = push_q && !fifo_in_ready;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wcnt_q  <= 2'h0;
            grp_q   <= '0;
            pdata_q <= '0;
            push_q  <= 1'b0;
        end else begin
            wcnt_q  <= wcnt_d;
            grp_q   <= grp_d;
            pdata_q <= pdata_d;
            push_q  <= push_d;
        end
    end

    logic             fifo_out_valid, fifo_out_ready;
    logic [GW*DW-1:0] fifo_out_data;

    sample_fifo #(
        .W     (GW*DW),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .rst_b     (rst_b),
        .in_valid  (push_q),
        .in_ready  (fifo_in_ready),
        .in_data   (pdata_q),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready),
        .out_data  (fifo_out_data)
    );

    // ---------------- Register file ----------------
    logic [7:0] coef_q [8];
    logic [7:0] coef_d [8];
    logic       sed_err_q, sed_err_d, ovf_q, ovf_d;
    logic [7:0] rdata_d, rdata_q;
    logic       clr_wr;

    // Sticky flags: a new event in the clearing cycle still lands
    always_comb begin
        coef_d    = coef_q;
        delay_d   = delay_q;
        ctrl_d    = ctrl_q;
        pattern_d = pattern_q;
        clr_wr    = reg_we && (reg_addr == dp_pkg::CAPTURE_STATUS_ADDR);
        if (reg_we) begin
            if (reg_addr >= dp_pkg::COEF_BASE_ADDR && reg_addr <= dp_pkg::COEF_LAST_ADDR) begin
                // Spare top bits of the last byte carry no coefficient
                coef_d[reg_addr[2:0]] = (reg_addr == dp_pkg::COEF_LAST_ADDR) ?
                                        {6'h00, reg_wdata[1:0]} : reg_wdata;
            end else if (reg_addr == dp_pkg::CAPTURE_DELAY_ADDR) begin
                delay_d = reg_wdata[dp_pkg::DELAY_W-1:0];
            end else if (reg_addr == dp_pkg::PATH_CTRL_ADDR) begin
                ctrl_d = {5'h00, reg_wdata[2:0]};
            end else if (reg_addr == dp_pkg::SED_PATTERN_LO_ADDR) begin
                pattern_d[7:0] = reg_wdata;
            end else if (reg_addr == dp_pkg::SED_PATTERN_HI_ADDR) begin
                pattern_d[15:8] = reg_wdata;
            end
        end
        sed_err_d = sed_hit || (sed_err_q && !(clr_wr && reg_wdata[dp_pkg::STAT_SED_BIT]));
        ovf_d     = ovf_hit || (ovf_q && !(clr_wr && reg_wdata[dp_pkg::STAT_OVF_BIT]));
        if (reg_addr >= dp_pkg::COEF_BASE_ADDR && reg_addr <= dp_pkg::COEF_LAST_ADDR) begin
            rdata_d = coef_q[reg_addr[2:0]];
        end else if (reg_addr == dp_pkg::CAPTURE_DELAY_ADDR) begin
            rdata_d = {6'h00, delay_q};
        end else if (reg_addr == dp_pkg::PATH_CTRL_ADDR) begin
            rdata_d = ctrl_q;
        end else if (reg_addr == dp_pkg::CAPTURE_STATUS_ADDR) begin
            rdata_d = {6'h00, ovf_q, sed_err_q};
        end else if (reg_addr == dp_pkg::SED_PATTERN_LO_ADDR) begin
            rdata_d = pattern_q[7:0];
        end else if (reg_addr == dp_pkg::SED_PATTERN_HI_ADDR) begin
            rdata_d = pattern_q[15:8];
        end else begin
            rdata_d = 8'h00;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int k = 0; k < 8; k++) begin
                coef_q[k] <= dp_pkg::REG_RESET;
            end
            delay_q   <= '0;
            ctrl_q    <= dp_pkg::REG_RESET;
            pattern_q <= '0;
            sed_err_q <= 1'b0;
            ovf_q     <= 1'b0;
            rdata_q   <= 8'h00;
        end else begin
            coef_q    <= coef_d;
            delay_q   <= delay_d;
            ctrl_q    <= ctrl_d;
            pattern_q <= pattern_d;
            sed_err_q <= sed_err_d;
            ovf_q     <= ovf_d;
            rdata_q   <= rdata_d;
        end
    end

    // ---------------- Coefficient unpacking ----------------
    logic [63:0] coef_flat;
    logic signed [dp_pkg::COEF_MAX_W-1:0] cr [dp_pkg::NUM_COEF];
    logic signed [dp_pkg::COEF_MAX_W-1:0] ci [dp_pkg::NUM_COEF];
    logic signed [dp_pkg::COEF_MAX_W:0]   hr [NT];
    logic signed [dp_pkg::COEF_MAX_W:0]   hi [NT];

    assign coef_flat = {coef_q[7], coef_q[6], coef_q[5], coef_q[4],
                        coef_q[3], coef_q[2], coef_q[1], coef_q[0]};

    // Sign-extend each packed field to the widest coefficient
    for (genvar k = 0; k < dp_pkg::NUM_COEF; k++) begin : g_coef
        assign cr[k] = dp_pkg::COEF_MAX_W'($signed(
            coef_flat[dp_pkg::COEF_RE_LSB[k] +: dp_pkg::COEF_W[k]]));
        assign ci[k] = dp_pkg::COEF_MAX_W'($signed(
            coef_flat[dp_pkg::COEF_IM_LSB[k] +: dp_pkg::COEF_W[k]]));
    end

    // Upper taps mirror the lower ones with the imaginary part negated
    for (genvar n = 0; n < NT; n++) begin : g_tap
        if (n < dp_pkg::NUM_COEF) begin : g_lo
            assign hr[n] = (dp_pkg::COEF_MAX_W+1)'(cr[n]);
            assign hi[n] = (dp_pkg::COEF_MAX_W+1)'(ci[n]);
        end else begin : g_hi
            assign hr[n] = (dp_pkg::COEF_MAX_W+1)'(cr[NT-1-n]);
            assign hi[n] = -(dp_pkg::COEF_MAX_W+1)'(ci[NT-1-n]);
        end
    end

    // ---------------- Premodulation and complex FIR ----------------
    logic signed [DW-1:0] xi_q [NP][NT];
    logic signed [DW-1:0] xq_q [NP][NT];
    logic signed [DW-1:0] xi_d [NP][NT];
    logic signed [DW-1:0] xq_d [NP][NT];
    logic signed [DW-1:0] yi_q [NP];
    logic signed [DW-1:0] yq_q [NP];
    logic signed [DW-1:0] yi_d [NP];
    logic signed [DW-1:0] yq_d [NP];
    logic                 phase_q, phase_d;
    logic                 out_valid_q, out_valid_d;
    logic                 pop;

    // Filter steps once per input group, so it runs at the data rate
    always_comb begin
        logic signed [ACCW-1:0] acc_i;
        logic signed [ACCW-1:0] acc_q;
        logic signed [ACCW-1:0] rnd;
        logic signed [DW-1:0]   si;
        logic signed [DW-1:0]   sq;
        acc_i          = '0;
        acc_q          = '0;
        si             = '0;
        sq             = '0;
        rnd            = ACCW'(1) <<< (FIR_SHIFT - 1);
        fifo_out_ready = !out_valid_q || out_ready;
        pop            = fifo_out_valid && fifo_out_ready;
        xi_d           = xi_q;
        xq_d           = xq_q;
        yi_d           = yi_q;
        yq_d           = yq_q;
        phase_d        = ctrl_q[dp_pkg::CTRL_PREMOD_BIT] ? (phase_q ^ pop) : 1'b0;
        out_valid_d    = pop || (out_valid_q && !out_ready);
        for (int p = 0; p < NP; p++) begin
            // Premodulation comes first, ahead of the filter
            si = fifo_out_data[(2*p)*DW +: DW];
            sq = fifo_out_data[(2*p+1)*DW +: DW];
            if (phase_q) begin
                si = sat_dw(-ACCW'(si));
                sq = sat_dw(-ACCW'(sq));
            end
            if (pop) begin
                for (int n = NT-1; n > 0; n--) begin
                    xi_d[p][n] = xi_q[p][n-1];
                    xq_d[p][n] = xq_q[p][n-1];
                end
                xi_d[p][0] = si;
                xq_d[p][0] = sq;
            end
            acc_i = '0;
            acc_q = '0;
            // Four real sections: real and imaginary taps on each of I and Q
            for (int n = 0; n < NT; n++) begin
                acc_i = acc_i + ACCW'(hr[n]) * ACCW'(xi_d[p][n])
                              - ACCW'(hi[n]) * ACCW'(xq_d[p][n]);
                acc_q = acc_q + ACCW'(hi[n]) * ACCW'(xi_d[p][n])
                              + ACCW'(hr[n]) * ACCW'(xq_d[p][n]);
            end
            if (pop) begin
                // Real streams must not mix I and Q, so the filter is bypassed
                if (ctrl_q[dp_pkg::CTRL_REAL_BIT]) begin
                    yi_d[p] = xi_d[p][0];
                    yq_d[p] = xq_d[p][0];
                end else begin
                    yi_d[p] = sat_dw((acc_i + rnd) >>> FIR_SHIFT);
                    yq_d[p] = sat_dw((acc_q + rnd) >>> FIR_SHIFT);
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int p = 0; p < NP; p++) begin
                for (int n = 0; n < NT; n++) begin
                    xi_q[p][n] <= '0;
                    xq_q[p][n] <= '0;
                end
                yi_q[p] <= '0;
                yq_q[p] <= '0;
            end
            phase_q     <= 1'b0;
            out_valid_q <= 1'b0;
        end else begin
            xi_q        <= xi_d;
            xq_q        <= xq_d;
            yi_q        <= yi_d;
            yq_q        <= yq_d;
            phase_q     <= phase_d;
            out_valid_q <= out_valid_d;
        end
    end

    assign reg_rdata = rdata_q;
    assign out_valid = out_valid_q;
    assign path0_i   = yi_q[0];
    assign path0_q   = yq_q[0];
    assign path1_i   = yi_q[1];
    assign path1_q   = yq_q[1];
endmodule
`default_nettype wire

/* File: hw/sample_fifo.sv */
// Group FIFO with registered read data between capture and filter.
`timescale 1ns/100ps
`default_nettype none
module sample_fifo #(
    parameter int W     = 64,
    parameter int DEPTH = 16,
    parameter int AW    = $clog2(DEPTH)
) (
    input  wire logic         clk,
    input  wire logic         rst_b,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    logic [W-1:0]  mem [DEPTH];
    logic [AW-1:0] wptr_q, wptr_d, rptr_q, rptr_d;
    logic [AW:0]   cnt_q, cnt_d;
    logic [W-1:0]  oreg_q, oreg_d;
    logic          ovalid_q, ovalid_d;
    logic          push, load;

    // Output register refills whenever it is empty or being drained
    always_comb begin
        in_ready = (cnt_q != (AW+1)'(DEPTH));
        push     = in_valid && in_ready;
        load     = (cnt_q != '0) && (!ovalid_q || out_ready);
        wptr_d   = push ? ((wptr_q == AW'(DEPTH-1)) ? '0 : wptr_q + 1'b1) : wptr_q;
        rptr_d   = load ? ((rptr_q == AW'(DEPTH-1)) ? '0 : rptr_q + 1'b1) : rptr_q;
        cnt_d    = cnt_q + (AW+1)'(push) - (AW+1)'(load);
        oreg_d   = load ? mem[rptr_q] : oreg_q;
        ovalid_d = load || (ovalid_q && !out_ready);
    end

    // Storage needs no reset; pointers guard every read
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wptr_q] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wptr_q   <= '0;
            rptr_q   <= '0;
            cnt_q    <= '0;
            oreg_q   <= '0;
            ovalid_q <= 1'b0;
        end else begin
            wptr_q   <= wptr_d;
            rptr_q   <= rptr_d;
            cnt_q    <= cnt_d;
            oreg_q   <= oreg_d;
            ovalid_q <= ovalid_d;
        end
    end

    assign out_valid = ovalid_q;
    assign out_data  = oreg_q;
endmodule
`default_nettype wire

/* File: sim/dp_monitor.sv */
// Port checker for the premodulation and inverse-sinc front end.
`timescale 1ns/100ps
`default_nettype none
module dp_monitor #(
    parameter int DW = 16
) (
    input wire logic          clk,
    input wire logic          rst_b,
    input wire logic          source_data_clock,
    input wire logic [DW-1:0] data_in,
    input wire logic          frame_in,
    input wire logic [7:0]    reg_addr,
    input wire logic [7:0]    reg_wdata,
    input wire logic          reg_we,
    input wire logic [7:0]    reg_rdata,
    input wire logic          out_ready,
    input wire logic          out_valid,
    input wire logic [DW-1:0] path0_i,
    input wire logic [DW-1:0] path0_q,
    input wire logic [DW-1:0] path1_i,
    input wire logic [DW-1:0] path1_q
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    // Write, then the same place presented again without a write
    sequence s_wr_rd(logic [7:0] lo, logic [7:0] hi);
        reg_we && reg_addr >= lo && reg_addr <= hi ##1 !reg_we && reg_addr == $past(reg_addr);
    endsequence
    a_out_stall_holds: assert property (
        out_valid && !out_ready |=> out_valid && $stable(path0_i) && $stable(path0_q)
        && $stable(path1_i) && $stable(path1_q)) else $error("result moved while stalled");
    a_coef_wr_rd: assert property (
        s_wr_rd(8'h20, 8'h26) |=> reg_rdata == $past(reg_wdata, 2))
        else $error("coefficient byte lost");
    a_coef_top_bits: assert property (
        reg_addr == 8'h27 |=> reg_rdata[7:2] == 6'h00) else $error("unused bits set");
    a_delay_wr_rd: assert property (
        s_wr_rd(8'h72, 8'h72) |=> reg_rdata == ($past(reg_wdata, 2) & 8'h03))
        else $error("delay field lost");
    a_delay_rsvd_zero: assert property (
        reg_addr == 8'h72 |=> reg_rdata[7:2] == 6'h00) else $error("delay spare bits set");
    a_unmapped_zero: assert property (
        reg_addr == 8'h30 || reg_addr == 8'h28 |=> reg_rdata == 8'h00)
        else $error("unmapped read nonzero");
    a_ctrl_wr_rd: assert property (
        s_wr_rd(8'h68, 8'h68) |=> reg_rdata == ($past(reg_wdata, 2) & 8'h07))
        else $error("control lost");
    a_reset_quiet: assert property (
        $rose(rst_b) |-> !out_valid ##1 !out_valid) else $error("output without capture");
endmodule
bind premod_inverse_sinc_datapath dp_monitor #(.DW(DW)) u_mon (
    .clk(clk), .rst_b(rst_b), .source_data_clock(source_data_clock), .data_in(data_in),
    .frame_in(frame_in), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
    .reg_rdata(reg_rdata), .out_ready(out_ready), .out_valid(out_valid),
    .path0_i(path0_i), .path0_q(path0_q), .path1_i(path1_i), .path1_q(path1_q));
`default_nettype wire

/* File: sim/dp_source.sv */
// Behavioural baseband source driving the dual-edge parallel data port.
`timescale 1ns/100ps
`default_nettype none
module dp_source #(
    parameter int DW = 16
) (
    output logic          source_data_clock,
    output logic [DW-1:0] data_in,
    output logic          frame_in
);
    initial begin
        source_data_clock = 1'b0;
        data_in           = '0;
        frame_in          = 1'b0;
    end
    // One group I0 Q0 I1 Q1, one word per link clock edge
    task automatic send(input logic [DW-1:0] w [4], input int gap);
        for (int k = 0; k < 4; k++) begin
            data_in  = w[k];
            frame_in = (k == 0);
            #1;
            source_data_clock = ~source_data_clock;
            #31;
        end
        // Released lines show the inverse, so stale data never passes
        if (gap > 0) begin
            data_in = ~w[3];
            #(gap);
        end
    endtask
endmodule
`default_nettype wire

/* File: sim/tb_top.sv */
// Self-checking bench: registers, capture, premodulation, filter, buffer.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    localparam int DW = 16;
    logic          clk, rst_b, sdc, frame, we, o_rdy, o_vld;
    logic [DW-1:0] din, p0i, p0q, p1i, p1q;
    logic [7:0]    addr, wdata, rdata;
    logic [63:0]   exp_q [$];
    logic [31:0]   seed = 32'hD1FA;
    int            err_count, total_checks, ph, premod_en, real_en, rdy_stall;
    int            cr [5], ci [5], xi [2][9], xq [2][9];
    dp_source #(.DW(DW)) src (.source_data_clock(sdc), .data_in(din), .frame_in(frame));
    premod_inverse_sinc_datapath #(.DW(DW)) dut (
        .clk(clk), .rst_b(rst_b), .source_data_clock(sdc), .data_in(din), .frame_in(frame),
        .reg_addr(addr), .reg_wdata(wdata), .reg_we(we), .reg_rdata(rdata), .out_ready(o_rdy),
        .out_valid(o_vld), .path0_i(p0i), .path0_q(p0q), .path1_i(p1i), .path1_q(p1q));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic int sat(input int v);
        return v > 32767 ? 32767 : (v < -32768 ? -32768 : v);
    endfunction
    task automatic check(input logic [63:0] seen, input logic [63:0] want);
        total_checks++;
        if (seen !== want) begin
            err_count++;
            $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask
    // Reference group: premodulate, shift both paths, nine conjugate taps
    function automatic void expect_group(input logic [DW-1:0] w [4]);
        int x [4], y [4], si, sq, hr, hm;
        for (int k = 0; k < 4; k++) begin
            x[k] = $signed(w[k]);
            if (ph != 0) x[k] = sat(-x[k]);
        end
        ph = premod_en ? 1 - ph : 0;
        for (int p = 0; p < 2; p++) begin
            for (int n = 8; n > 0; n--) begin
                xi[p][n] = xi[p][n-1];
                xq[p][n] = xq[p][n-1];
            end
            xi[p][0] = x[2*p];
            xq[p][0] = x[2*p+1];
            si = 1 << (dp_pkg::FIR_SHIFT - 1);
            sq = si;
            for (int n = 0; n < 9; n++) begin
                hr = n < 5 ? cr[n] : cr[8-n];
                hm = n < 5 ? ci[n] : -ci[8-n];
                si += hr * xi[p][n] - hm * xq[p][n];
                sq += hm * xi[p][n] + hr * xq[p][n];
            end
            y[2*p] = real_en ? x[2*p] : sat(si >>> dp_pkg::FIR_SHIFT);
            y[2*p+1] = real_en ? x[2*p+1] : sat(sq >>> dp_pkg::FIR_SHIFT);
        end
        exp_q.push_back({DW'(y[0]), DW'(y[1]), DW'(y[2]), DW'(y[3])});
    endfunction
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        addr = a;
        wdata = d;
        we = 1'b1;
        @(negedge clk);
        we = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge clk);
        addr = a;
        @(negedge clk);
        check(64'(rdata), 64'(e));
    endtask
    task automatic ctrl(input logic [7:0] v);
        wr(8'h68, v);
        premod_en = v[0];
        real_en = v[1];
        ph = v[0] ? ph : 0;
    endtask
    // Pack the coefficient set into the eight bytes, then read it back
    task automatic load();
        logic [63:0] v;
        v = '0;
        for (int k = 0; k < 5; k++) begin
            v |= (64'(cr[k]) & ((64'h1 << dp_pkg::COEF_W[k]) - 1)) << dp_pkg::COEF_RE_LSB[k];
            v |= (64'(ci[k]) & ((64'h1 << dp_pkg::COEF_W[k]) - 1)) << dp_pkg::COEF_IM_LSB[k];
        end
        for (int b = 0; b < 8; b++) wr(8'h20 + 8'(b), v[8*b +: 8]);
        for (int b = 0; b < 8; b++) rd(8'h20 + 8'(b), v[8*b +: 8]);
    endtask
    task automatic grp(input int gap, input bit keep, input bit fix, input logic [DW-1:0] w0);
        logic [DW-1:0] w [4];
        for (int k = 0; k < 4; k++) w[k] = DW'(rnd());
        if (fix) w[0] = w0;
        if (keep) expect_group(w);
        src.send(w, gap);
    endtask
    task automatic drain();
        for (int n = 0; n < 4000 && exp_q.size() > 0; n++) @(negedge clk);
        check(64'(exp_q.size()), 64'h0);
        repeat (20) @(negedge clk);
    endtask
    task automatic final_report();
        $display("checks=%0d errors=%0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // Far side ready: random unless a stall is wanted
    always @(negedge clk) o_rdy <= rdy_stall ? 1'b0 : 1'(rnd() >> 7);
    // Oldest expectation against each consumed result
    always @(posedge clk) begin
        if (rst_b === 1'b1 && o_vld === 1'b1 && o_rdy === 1'b1) begin
            check({p0i, p0q, p1i, p1q}, exp_q.size() > 0 ? exp_q.pop_front() : 64'hX);
        end
    end
    initial begin
        #300000;
        err_count++;
        $display("watchdog expired at %0t", $time);
        final_report();
    end
    initial begin
        rst_b = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
        we = 1'b0;
        repeat (16) @(negedge clk);
        rst_b = 1'b1;
        repeat (2) @(negedge clk);
        for (int a = 8'h20; a <= 8'h27; a++) rd(8'(a), 8'h00);
        wr(8'h30, 8'hFF);
        rd(8'h30, 8'h00);
        wr(8'h27, 8'hFF);
        rd(8'h27, 8'h03);
        wr(8'h72, 8'hFF);
        rd(8'h72, 8'h03);
        for (int k = 0; k < 5; k++) begin
            cr[k] = $signed(rnd()) >>> (32 - dp_pkg::COEF_W[k]);
            ci[k] = $signed(rnd()) >>> (32 - dp_pkg::COEF_W[k]);
        end
        load();
        // Every capture delay code, prompt and slow groups
        for (int d = 0; d < 4; d++) begin
            wr(8'h72, 8'(d));
            repeat (3) grp(d * 40, 1, 0, '0);
            drain();
        end
        // Premodulation ahead of the filter, most negative word included; then real-only taps with premodulation off
        ctrl(8'h01);
        repeat (4) grp(0, 1, 1, 16'h8000);
        drain();
        ctrl(8'h00);
        cr = '{2, -4, 10, -35, 401};
        ci = '{0, 0, 0, 0, 0};
        load();
        repeat (3) grp(8, 1, 0, '0);
        drain();
        // Word zero against the stored pattern
        wr(8'h6A, 8'h5A);
        wr(8'h6B, 8'hC3);
        ctrl(8'h04);
        grp(0, 1, 1, 16'hC35A);
        drain();
        rd(8'h69, 8'h00);
        grp(0, 1, 1, 16'hC35B);
        drain();
        rd(8'h69, 8'h01);
        ctrl(8'h00);
        // Stall until the buffer refuses a whole group, then drain
        rdy_stall = 1;
        repeat (18) grp(0, 1, 0, '0);
        grp(0, 0, 0, '0);
        repeat (20) @(negedge clk);
        rd(8'h69, 8'h03);
        rdy_stall = 0;
        drain();
        wr(8'h69, 8'h03);
        rd(8'h69, 8'h00);
        // Real streams: premodulation only, no filtering
        ctrl(8'h03);
        repeat (2) grp(0, 1, 0, '0);
        drain();
        final_report();
    end
endmodule
`default_nettype wire
